// File: logic/eqdc_core.sv
// Error queue with overflow marking, plus remote device clear handling
// Assumes core_clk 25 MHz; external pins are synchronised here
// Function
// [RULE_01] Device clear flushes incoming command and outgoing response buffers.
// [RULE_02] Device clear leaves status, error queue and configuration intact.
// [RULE_03] After a clear the command receiver returns to idle.
// [RULE_04] Serial Ctrl-C acts exactly like a bus device clear.
// [RULE_05] After any device clear the DTR output is asserted.
// [RULE_06] Reads return errors oldest first.
// [RULE_07] Twenty entries; error when full overwrites newest with -350.
// [RULE_08] After overflow, new errors are dropped until one is read.
// [RULE_09] Reading an empty queue returns +0 and changes nothing.
// [RULE_10] Each read pops the returned entry.
// [RULE_11] Error indicator lit while the queue holds any entry.
// [RULE_12] One beeper pulse per error, dropped ones included.
// [RULE_13] Clear-status command and power-up empty the queue.
// [RULE_14] The reset common command leaves the queue unchanged.
// [RULE_15] Response is signed code, comma, quoted text up to 80 characters.
// [RULE_16] Leaving the error viewer by key or 30 s timeout clears all.
// [RULE_17] Pointers, count and overflow flag reset to empty at power-up.
// [RULE_18] Simultaneous push and pop: pop served first, then push stored.
`timescale 1ns/1ps
`include "eqdc_defs.svh"
module eqdc_core
  import eqdc_pkg::*;
#(
  parameter int        DEPTH     = `EQDC_DEPTH,
  parameter int        CODE_W    = `EQDC_CODE_W,
  parameter int        MSG_MAX   = `EQDC_MSG_MAX,
  parameter longint    VIEW_TO   = `EQDC_VIEW_TO_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // Remote interface pins
  input  wire logic              bus_dev_clear,
  input  wire logic              serial_mode,
  input  wire logic              serial_rx_valid,
  input  wire logic [7:0]        serial_rx_char,
  // Command side
  input  wire logic              cmd_byte_valid,
  input  wire logic              cmd_done,
  input  wire logic              cls_cmd,
  input  wire logic              rst_cmd,
  // Error sources and readout
  input  wire logic              err_push,
  input  wire logic [CODE_W-1:0] err_code,
  input  wire logic              err_pop,
  input  wire logic              view_active,
  input  wire logic              view_exit_key,
  input  wire logic              view_key_any,
  // Outputs
  output logic                   in_buf_flush,
  output logic                   out_buf_flush,
  output logic                   rx_idle,
  output logic                   dtr,
  output logic                   rd_valid,
  output logic [CODE_W-1:0]      rd_code,
  output logic                   rd_empty,
  output logic [6:0]             rd_msg_max,
  output logic                   err_led,
  output logic                   beep,
  output logic [4:0]             err_count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]        dcl_s;
    logic [1:0]        dcl_d;
    logic [1:0]        cc_v;
    logic [7:0]        cc_c1;
    logic [7:0]        cc_c2;
    logic              dcl_prev;
    eqdc_rx_t          rx;
    logic              in_flush;
    logic              out_flush;
    logic              dtr;
    logic [AW-1:0]     rptr;
    logic [AW-1:0]     wptr;
    logic [CW-1:0]     count;
    logic              ovf;
    logic              rd_valid;
    logic [CODE_W-1:0] rd_code;
    logic              rd_empty;
    logic              beep;
    logic              view_prev;
    logic [31:0]       idle_cnt;
    logic              rx_idle;
    logic              led;
    logic [6:0]        msg_max;
  } eqdc_state_t;

  eqdc_state_t       cur;
  eqdc_state_t       nxt;
  logic [CODE_W-1:0] mem [DEPTH];
  logic              wr_en;
  logic [AW-1:0]     wr_addr;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == LAST) ? '0 : p + AW'(1);
  endfunction

  function automatic logic [AW-1:0] dec(input logic [AW-1:0] p);
    dec = (p == '0) ? LAST : p - AW'(1);
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic dcl_req;
    logic ctrl_c;
    logic pop;
    logic clr_all;
    logic view_leave;
    logic [CW-1:0] cnt_after;
    dcl_req    = 1'b0;
    ctrl_c     = 1'b0;
    pop        = 1'b0;
    clr_all    = 1'b0;
    view_leave = 1'b0;
    cnt_after  = '0;
    nxt     = cur;
    wr_en   = 1'b0;
    wr_addr = cur.wptr;
    // Two-stage synchronisers for external pins
    nxt.dcl_s = {cur.dcl_s[0], bus_dev_clear};
    nxt.dcl_d = {cur.dcl_d[0], serial_mode};
    nxt.cc_v  = {cur.cc_v[0], serial_rx_valid};
    nxt.cc_c1 = serial_rx_char;
    nxt.cc_c2 = cur.cc_c1;
    nxt.dcl_prev = cur.dcl_s[1];
    ctrl_c  = cur.dcl_d[1] && cur.cc_v[1]
              && (cur.cc_c2 == `EQDC_CTRL_C);          // [RULE_04]
    dcl_req = (cur.dcl_s[1] && !cur.dcl_prev) || ctrl_c;

    // Receiver and buffer flush; queue state is not touched here
    nxt.in_flush  = 1'b0;
    nxt.out_flush = 1'b0;
    case (cur.rx)
      EQDC_RX_IDLE:  if (cmd_byte_valid) nxt.rx = EQDC_RX_BUSY;
      EQDC_RX_BUSY:  if (cmd_done) nxt.rx = EQDC_RX_IDLE;
      EQDC_RX_FLUSH: begin
        nxt.rx  = EQDC_RX_IDLE;                         // [RULE_03]
        nxt.dtr = 1'b1;                                 // [RULE_05]
      end
      default:       nxt.rx = EQDC_RX_IDLE;
    endcase
    if (dcl_req) begin
      nxt.in_flush  = 1'b1;                             // [RULE_01]
      nxt.out_flush = 1'b1;                             // [RULE_01] [RULE_02]
      nxt.rx        = EQDC_RX_FLUSH;
    end

    // Error viewer exit by key or inactivity timeout
    nxt.view_prev = view_active;
    if (!view_active || view_key_any)
      nxt.idle_cnt = '0;
    else if (64'(cur.idle_cnt) < 64'(VIEW_TO))
      nxt.idle_cnt = cur.idle_cnt + 32'd1;
    view_leave = view_active
                 && (view_exit_key
                     || 64'(cur.idle_cnt) >= 64'(VIEW_TO) - 64'd1); // [RULE_16]
    clr_all = cls_cmd || view_leave;                    // [RULE_13] [RULE_16]
    // rst_cmd intentionally has no effect on the queue  [RULE_14]

    // Readout: pop first, then push  [RULE_18]
    nxt.rd_valid = 1'b0;
    nxt.beep     = err_push;                            // [RULE_12]
    pop = err_pop && (cur.count != '0);
    if (err_pop) begin
      nxt.rd_valid = 1'b1;
      nxt.rd_empty = (cur.count == '0);
      nxt.rd_code  = pop ? mem[cur.rptr]                // [RULE_06] [RULE_15]
                         : CODE_W'(`EQDC_CODE_NONE);    // [RULE_09]
    end
    cnt_after = cur.count;
    if (pop) begin
      nxt.rptr  = inc(cur.rptr);                        // [RULE_10]
      cnt_after = cur.count - CW'(1);
      nxt.ovf   = 1'b0;                                 // [RULE_08]
    end
    if (err_push) begin
      if (cnt_after < CW'(DEPTH)) begin
        wr_en     = 1'b1;
        nxt.wptr  = inc(cur.wptr);
        cnt_after = cnt_after + CW'(1);
      end else if (!cur.ovf || pop) begin
        wr_en    = 1'b1;                                // [RULE_07]
        wr_addr  = dec(cur.wptr);
        nxt.ovf  = 1'b1;
      end
    end
    nxt.count = cnt_after;
    if (clr_all) begin
      nxt.rptr  = '0;
      nxt.wptr  = '0;
      nxt.count = '0;
      nxt.ovf   = 1'b0;
      wr_en     = 1'b0;
    end

    // Registered copies so every output leaves a flip-flop
    nxt.rx_idle = (nxt.rx == EQDC_RX_IDLE);             // [RULE_03]
    nxt.led     = (nxt.count != '0);                    // [RULE_11]
    nxt.msg_max = 7'(MSG_MAX);                          // [RULE_15]
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur          <= '0;                               // [RULE_17] [RULE_13]
      cur.rx       <= EQDC_RX_IDLE;
      cur.dtr      <= 1'b1;
      cur.rd_empty <= 1'b1;
      cur.rx_idle  <= 1'b1;
      cur.msg_max  <= 7'(MSG_MAX);
    end else if (clk_en) begin
      cur <= nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= (wr_addr == cur.wptr) ? err_code
                                            : CODE_W'(`EQDC_CODE_OVF);
    end
  end

  // ==========================================================
  // Outputs
  assign in_buf_flush  = cur.in_flush;
  assign out_buf_flush = cur.out_flush;
  assign rx_idle       = cur.rx_idle;
  assign dtr           = cur.dtr;
  assign rd_valid      = cur.rd_valid;
  assign rd_code       = cur.rd_code;
  assign rd_empty      = cur.rd_empty;
  assign rd_msg_max    = cur.msg_max;                   // [RULE_15]
  assign err_led       = cur.led;                       // [RULE_11]
  assign beep          = cur.beep;
  assign err_count     = 5'(cur.count);

endmodule

// File: logic/eqdc_defs.svh
// Constants for the error queue and device clear block
// Assumes inclusion by eqdc_pkg and the design module only
`ifndef EQDC_DEFS_SVH
`define EQDC_DEFS_SVH
`define EQDC_DEPTH        20
`define EQDC_CODE_W       16
`define EQDC_CODE_OVF     16'hFEA2
`define EQDC_CODE_NONE    16'h0000
`define EQDC_MSG_MAX      80
`define EQDC_CLK_NS       40
`define EQDC_VIEW_TO_S    30
`define EQDC_VIEW_TO_CYC  ((`EQDC_VIEW_TO_S * 64'd1_000_000_000) / \
                           `EQDC_CLK_NS)
`define EQDC_CTRL_C       8'h03
`endif

// File: logic/eqdc_pkg.sv
// Types for the error queue and device clear block
// Assumes the constants header is on the include path
`include "eqdc_defs.svh"
package eqdc_pkg;
  typedef enum logic [1:0] {EQDC_RX_IDLE, EQDC_RX_BUSY, EQDC_RX_FLUSH}
    eqdc_rx_t;
endpackage

// File: sim/eqdc_core_assertions.sv
// Checker for the error queue and device clear ports
// Assumes it is bound onto every eqdc_core instance
`timescale 1ns/1ps
module eqdc_core_chk #(
  parameter int CODE_W = 16
) (
  // Clock, reset and enable
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              clk_en,
  // Requests
  input wire logic              err_push,
  input wire logic              err_pop,
  input wire logic              cls_cmd,
  input wire logic              view_active,
  // Results
  input wire logic              in_buf_flush,
  input wire logic              out_buf_flush,
  input wire logic              rx_idle,
  input wire logic              dtr,
  input wire logic [CODE_W-1:0] rd_code,
  input wire logic              rd_empty,
  input wire logic              err_led,
  input wire logic              beep,
  input wire logic [4:0]        err_count
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rearm; ##[0:2] (rx_idle && dtr); endsequence
  property p_beep; clk_en && err_push |=> beep; endproperty
  property p_led; err_led == (err_count != 5'h00); endproperty
  property p_flush; in_buf_flush |-> out_buf_flush; endproperty
  property p_rearm; in_buf_flush |=> s_rearm; endproperty
  property p_empty; clk_en && err_pop && !err_push && err_count == 5'h00
    |=> rd_empty && rd_code == 16'h0000; endproperty
  property p_pop; clk_en && err_pop && !err_push && !cls_cmd && !view_active
    && err_count != 5'h00 |=> err_count == $past(err_count) - 5'h01;
  endproperty
  property p_cls; clk_en && cls_cmd |=> err_count == 5'h00; endproperty
  property p_max; err_count <= 5'h14; endproperty
  a_beep: assert property (p_beep) else $error("no beep");
  a_led: assert property (p_led) else $error("led wrong");
  a_flush: assert property (p_flush) else $error("flush");
  a_rearm: assert property (p_rearm) else $error("rearm");
  a_empty: assert property (p_empty) else $error("empty");
  a_pop: assert property (p_pop) else $error("pop count");
  a_cls: assert property (p_cls) else $error("cls");
  a_max: assert property (p_max) else $error("over 20");
endmodule
bind eqdc_core eqdc_core_chk #(.CODE_W(CODE_W)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
  .err_push(err_push), .err_pop(err_pop), .cls_cmd(cls_cmd),
  .view_active(view_active), .in_buf_flush(in_buf_flush),
  .out_buf_flush(out_buf_flush), .rx_idle(rx_idle), .dtr(dtr),
  .rd_code(rd_code), .rd_empty(rd_empty), .err_led(err_led),
  .beep(beep), .err_count(err_count));

// File: sim/eqdc_ctl_model.sv
// Remote controller model: bus device clear and serial characters
// Assumes the bench calls its tasks; pins move after falling edges
`timescale 1ns/1ps
module eqdc_ctl_model (
  // Clock
  input wire logic   core_clk,
  // Remote pins
  output logic       bus_dev_clear,
  output logic       serial_mode,
  output logic       serial_rx_valid,
  output logic [7:0] serial_rx_char
);
  initial begin
    bus_dev_clear = 1'b0;
    serial_mode = 1'b0;
    serial_rx_valid = 1'b0;
    serial_rx_char = 8'hA5;
  end
  task automatic dev_clear();
    @(negedge core_clk);
    bus_dev_clear = 1'b1;
    @(negedge core_clk);
    bus_dev_clear = 1'b0;
  endtask
  // Idle data inverted so a stale 03 is never seen
  task automatic ctrl_c();
    @(negedge core_clk);
    serial_mode = 1'b1;
    serial_rx_char = 8'h03;
    serial_rx_valid = 1'b1;
    @(negedge core_clk);
    serial_rx_valid = 1'b0;
    serial_rx_char = 8'hFC;
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for eqdc_core
// Assumes the controller model drives the remote pins
`timescale 1ns/1ps
module tb;
  int          failures = 0;
  int          checked = 0;
  logic        core_clk, rst_b = 1'b0, bus_dev_clear, serial_mode;
  logic        serial_rx_valid, in_buf_flush, out_buf_flush, rx_idle;
  logic        dtr, rd_valid, rd_empty, err_led, beep;
  logic        err_push = 1'b0, err_pop = 1'b0, cls_cmd = 1'b0;
  logic        rst_cmd = 1'b0, view_active = 1'b0, view_exit_key = 1'b0;
  logic        cmd_byte_valid = 1'b0, clk_en = 1'b1;
  logic [7:0]  serial_rx_char;
  logic [15:0] err_code = 16'h0000, rd_code;
  logic [6:0]  rd_msg_max;
  logic [4:0]  err_count;
  eqdc_ctl_model u_ctl (.core_clk(core_clk), .bus_dev_clear(bus_dev_clear),
    .serial_mode(serial_mode), .serial_rx_valid(serial_rx_valid),
    .serial_rx_char(serial_rx_char));
  eqdc_core #(.VIEW_TO(50)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .bus_dev_clear(bus_dev_clear), .serial_mode(serial_mode),
    .serial_rx_valid(serial_rx_valid), .serial_rx_char(serial_rx_char),
    .cmd_byte_valid(cmd_byte_valid), .cmd_done(1'b0), .cls_cmd(cls_cmd),
    .rst_cmd(rst_cmd), .err_push(err_push), .err_code(err_code),
    .err_pop(err_pop), .view_active(view_active),
    .view_exit_key(view_exit_key), .view_key_any(1'b0),
    .in_buf_flush(in_buf_flush), .out_buf_flush(out_buf_flush),
    .rx_idle(rx_idle), .dtr(dtr), .rd_valid(rd_valid), .rd_code(rd_code),
    .rd_empty(rd_empty), .rd_msg_max(rd_msg_max), .err_led(err_led),
    .beep(beep), .err_count(err_count));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========
  // Helpers
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic push(input logic [15:0] c);
    err_code = c;
    pulse(err_push);
    chk(beep === 1'b1, "no beep");
  endtask
  task automatic pop(input logic [15:0] e);
    pulse(err_pop);
    chk(rd_valid === 1'b1 && rd_code === e, "bad read");
  endtask
  task automatic wait_flush();
    int n;
    n = 0;
    while (in_buf_flush !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    chk(out_buf_flush === 1'b1 && n < 12, "no flush");
    if (n == 12)
      print_verdict();
    repeat (3) @(negedge core_clk);
    chk(rx_idle === 1'b1 && dtr === 1'b1, "not rearmed");
    chk(err_count === 5'h02, "queue touched");
  endtask
  // ==========
  // Scenarios
  task automatic t_queue();
    chk(err_count === 5'h00 && rd_msg_max === 7'h50, "reset");
    pop(16'h0000);
    chk(rd_empty === 1'b1 && err_led === 1'b0, "empty");
    for (int i = 1; i <= 22; i++)
      push(16'(i));
    chk(err_count === 5'h14 && err_led === 1'b1, "full");
    for (int i = 1; i <= 19; i++)
      pop(16'(i));
    pop(16'hFEA2);
    chk(err_led === 1'b0, "led on");
  endtask
  task automatic t_clear();
    push(16'h0005);
    push(16'h0006);
    pulse(cmd_byte_valid);
    chk(rx_idle === 1'b0, "not busy");
    u_ctl.dev_clear();
    wait_flush();
    u_ctl.ctrl_c();
    wait_flush();
    pulse(rst_cmd);
    chk(err_count === 5'h02, "reset cmd");
    err_code = 16'h0007;
    @(negedge core_clk);
    {err_push, err_pop} = 2'b11;
    @(negedge core_clk);
    {err_push, err_pop} = 2'b00;
    chk(rd_code === 16'h0005 && err_count === 5'h02, "push pop");
    pulse(cls_cmd);
    chk(err_count === 5'h00, "cls");
  endtask
  task automatic t_view();
    int n;
    push(16'h0008);
    view_active = 1'b1;
    pulse(view_exit_key);
    @(negedge core_clk);
    chk(err_count === 5'h00, "exit key");
    push(16'h0009);
    n = 0;
    while (err_count !== 5'h00 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 80, "no timeout");
    view_active = 1'b0;
  endtask
  task automatic t_freeze();
    push(16'h000A);
    clk_en = 1'b0;
    pulse(err_push);
    chk(err_count === 5'h01 && beep === 1'b1, "not frozen");
    clk_en = 1'b1;
    pop(16'h000A);
    chk(err_count === 5'h00 && err_led === 1'b0, "after freeze");
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    t_queue();
    t_clear();
    t_view();
    t_freeze();
    print_verdict();
  end
endmodule
